// ---- src/bst_params.svh ----
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// widths of the test registers
`define BST_IR_WIDTH 3
`define BST_BSR_LEN 108

// instruction codes
`define BST_IR_EXTEST 3'h0
`define BST_IR_SAMPLE 3'h1
`define BST_IR_HIGHZ 3'h4
`define BST_IR_BYPASS 3'h7

// value loaded into the instruction shift stage at capture-ir
`define BST_IR_CAPTURE 3'h1

// reset values
`define BST_RST_IR 3'h7
`define BST_RST_BYPASS 1'h0

// flops in each clock-crossing synchroniser
`define BST_SYNC_STAGES 3

`endif

// ---- src/bst_pkg.sv ----
package bst_pkg;

  // sixteen-state test controller
  typedef enum logic [3:0] {
    BST_TLR,
    BST_RTI,
    BST_SEL_DR,
    BST_CAP_DR,
    BST_SH_DR,
    BST_EX1_DR,
    BST_PAU_DR,
    BST_EX2_DR,
    BST_UPD_DR,
    BST_SEL_IR,
    BST_CAP_IR,
    BST_SH_IR,
    BST_EX1_IR,
    BST_PAU_IR,
    BST_EX2_IR,
    BST_UPD_IR
  } bst_state_t;

  // decoded meaning of the current instruction
  typedef enum logic [1:0] {
    BST_OP_EXTEST,
    BST_OP_SAMPLE,
    BST_OP_HIGHZ,
    BST_OP_BYPASS
  } bst_op_t;

endpackage : bst_pkg

// ---- src/bst_sync.sv ----
`include "bst_params.svh"

// per-bit level synchroniser: three flops, a new level is accepted once
// the second and third flop agree, so a single glitch is filtered out
module bst_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // destination clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // level from the other domain
  input wire logic [WIDTH-1:0] async_i,
  // filtered level in this domain
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q; // first stage, read by s2 only
  logic [WIDTH-1:0] s2_q; // second stage
  logic [WIDTH-1:0] s3_q; // third stage

  initial begin
    if (WIDTH < 1) begin
      $error("bst_sync: WIDTH must be at least 1");
    end
  end

  // shift chain
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept each bit only when the two later stages agree
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        sync_o[b] <= RST_VAL[b];
      end else if (s2_q[b] == s3_q[b]) begin
        sync_o[b] <= s3_q[b];
      end
    end
  end

endmodule // bst_sync

// ---- src/bst_bsr.sv ----
`include "bst_params.svh"

// boundary scan register: a shift stage and an update stage per cell;
// cell 0 sits next to the serial output
module bst_bsr #(
  parameter int LEN = `BST_BSR_LEN
) (
  // test clock domain
  input wire logic tck_i,
  input wire logic rst_i,
  // controller strobes
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  // serial path
  input wire logic tdi_i,
  output logic so_o,
  // parallel capture and update
  input wire logic [LEN-1:0] pin_i,
  output logic [LEN-1:0] upd_o
);

  logic [LEN-1:0] sh_q; // shift stage

  initial begin
    if (LEN < 2) begin
      $error("bst_bsr: LEN must be at least 2");
    end
  end

  // one cell per pin; shifting moves data toward cell 0
  for (genvar c = 0; c < LEN; c++) begin : g_cell
    logic nxt;
    if (c == LEN - 1) begin : g_top
      assign nxt = tdi_i; // last cell fed from serial input
    end else begin : g_mid
      assign nxt = sh_q[c+1];
    end

    // shift stage: capture pin value or shift
    always_ff @(posedge tck_i) begin
      if (rst_i) begin
        sh_q[c] <= 1'h0;
      end else if (capture_i) begin
        sh_q[c] <= pin_i[c];
      end else if (shift_i) begin
        sh_q[c] <= nxt;
      end
    end

    // update stage holds the value pins take in test mode
    always_ff @(posedge tck_i) begin
      if (rst_i) begin
        upd_o[c] <= 1'h0;
      end else if (update_i) begin
        upd_o[c] <= sh_q[c];
      end
    end
  end

  assign so_o = sh_q[0];

endmodule // bst_bsr

// ---- src/bst_tap.sv ----
`include "bst_params.svh"

module bst_tap
  import bst_pkg::*;
#(
  parameter int BSR_LEN = `BST_BSR_LEN
) (
  // system clock domain
  input wire logic clk_i,
  input wire logic srst_i,
  // test port, clocked by the test clock
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // system side pins
  input wire logic [BSR_LEN-1:0] core_out_i,
  input wire logic [BSR_LEN-1:0] pin_level_i,
  output logic [BSR_LEN-1:0] pin_out_o,
  output logic pin_drv_off_o,
  // status for observation
  output bst_pkg::bst_state_t tap_state_o,
  output logic [`BST_IR_WIDTH-1:0] ir_o
);

  import bst_pkg::*;

  // test clock domain state
  logic tck_rst; // system reset carried into test clock domain
  bst_state_t state_q; // controller state
  bst_state_t state_d; // next controller state
  logic [`BST_IR_WIDTH-1:0] ir_sh_q; // instruction shift stage
  logic [`BST_IR_WIDTH-1:0] ir_q; // active instruction
  bst_op_t op; // decoded active instruction
  logic byp_q; // bypass cell
  logic bsr_so; // boundary register serial out
  logic [BSR_LEN-1:0] bsr_upd; // boundary update stage
  logic [BSR_LEN-1:0] pin_tck; // pin levels seen in test domain
  logic dr_so; // selected data register output
  logic so_mux; // selected serial output before falling edge flop
  logic sel_bsr; // boundary register is the data register
  logic test_drive_q; // pins take update stage values
  logic test_off_q; // pin drivers disabled
  logic upd_tgl_q; // flips at every boundary update

  // system clock domain state
  logic [BSR_LEN-1:0] pin_snap_q; // pin levels registered in system domain
  logic upd_tgl_clk; // update toggle seen in system domain
  logic upd_seen_q; // toggle value already taken
  logic [BSR_LEN-1:0] upd_word_q; // update stage taken in system domain
  logic [1:0] mode_clk; // test modes seen in system domain
  logic [BSR_LEN-1:0] pin_out_q; // registered pin drive value
  logic drv_off_q; // registered driver disable

  initial begin
    if (BSR_LEN != `BST_BSR_LEN) begin
      $error("bst_tap: boundary register length is fixed by the pin count");
    end
  end

  // system reset reaches the test domain through a synchroniser; the
  // controller also resets itself by mode select, which needs no clock
  // but the test clock
  bst_sync #(
    .WIDTH(1),
    .RST_VAL(1'h1)
  ) u_rst_sync (
    .clk_i(tck_i),
    .srst_i(1'h0),
    .async_i(srst_i),
    .sync_o(tck_rst)
  );

  // next state of the controller; mode select read at rising edge
  always_comb begin
    case (state_q)
      BST_TLR: state_d = tms_i ? BST_TLR : BST_RTI;
      BST_RTI: state_d = tms_i ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_d = tms_i ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_d = tms_i ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: state_d = tms_i ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: state_d = tms_i ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: state_d = tms_i ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: state_d = tms_i ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: state_d = tms_i ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_d = tms_i ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: state_d = tms_i ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: state_d = tms_i ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: state_d = tms_i ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: state_d = tms_i ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: state_d = tms_i ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: state_d = tms_i ? BST_SEL_DR : BST_RTI;
      default: state_d = BST_TLR;
    endcase
  end

  // controller state register, on the test clock only
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      state_q <= BST_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  // instruction shift stage: fixed pattern at capture, serial load after
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      ir_sh_q <= `BST_RST_IR;
    end else if (state_q == BST_CAP_IR) begin
      ir_sh_q <= `BST_IR_CAPTURE;
    end else if (state_q == BST_SH_IR) begin
      ir_sh_q <= {tdi_i, ir_sh_q[`BST_IR_WIDTH-1:1]};
    end
  end

  // active instruction; reset selects bypass so pins stay normal
  always_ff @(posedge tck_i) begin
    if (tck_rst || state_q == BST_TLR) begin
      ir_q <= `BST_RST_IR;
    end else if (state_q == BST_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // decode; every code without a function falls to bypass
  always_comb begin
    case (ir_q)
      `BST_IR_EXTEST: op = BST_OP_EXTEST;
      `BST_IR_SAMPLE: op = BST_OP_SAMPLE;
      `BST_IR_HIGHZ: op = BST_OP_HIGHZ;
      default: op = BST_OP_BYPASS;
    endcase
  end

  assign sel_bsr = (op == BST_OP_EXTEST) || (op == BST_OP_SAMPLE);

  // bypass cell: captures zero, then one stage between input and output
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      byp_q <= `BST_RST_BYPASS;
    end else if (!sel_bsr && state_q == BST_CAP_DR) begin
      byp_q <= 1'h0;
    end else if (!sel_bsr && state_q == BST_SH_DR) begin
      byp_q <= tdi_i;
    end
  end

  // pin levels cross into the test domain bit by bit; each pin is an
  // independent level, so per-bit synchronising is safe here
  bst_sync #(
    .WIDTH(BSR_LEN),
    .RST_VAL('0)
  ) u_pin_sync (
    .clk_i(tck_i),
    .srst_i(tck_rst),
    .async_i(pin_snap_q),
    .sync_o(pin_tck)
  );

  // boundary register
  bst_bsr #(
    .LEN(BSR_LEN)
  ) u_bsr (
    .tck_i(tck_i),
    .rst_i(tck_rst),
    .capture_i(sel_bsr && state_q == BST_CAP_DR),
    .shift_i(sel_bsr && state_q == BST_SH_DR),
    .update_i(sel_bsr && state_q == BST_UPD_DR),
    .tdi_i(tdi_i),
    .so_o(bsr_so),
    .pin_i(pin_tck),
    .upd_o(bsr_upd)
  );

  // serial output source: instruction stage in shift-ir, else data reg
  assign dr_so = sel_bsr ? bsr_so : byp_q;
  assign so_mux = (state_q == BST_SH_IR) ? ir_sh_q[0] : dr_so;

  // output flop on the falling edge, so the tester samples a stable
  // bit at the next rising edge; enable low only in the shift states
  always_ff @(negedge tck_i) begin
    if (tck_rst) begin
      tdo_o <= 1'h1;
      tdo_oe_n_o <= 1'h1;
    end else begin
      tdo_o <= so_mux;
      tdo_oe_n_o <= !(state_q == BST_SH_IR || state_q == BST_SH_DR);
    end
  end

  // flips once per boundary update; the system side takes the whole
  // update stage when it sees the flip, so the pins change as one word
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      upd_tgl_q <= 1'h0;
    end else if (sel_bsr && state_q == BST_UPD_DR) begin
      upd_tgl_q <= !upd_tgl_q;
    end
  end

  // test mode levels, set at the same edge as the active instruction so
  // that a test clock stopped right after update-ir still reaches the pins
  always_ff @(posedge tck_i) begin
    if (tck_rst || state_q == BST_TLR) begin
      test_drive_q <= 1'h0;
      test_off_q <= 1'h0;
    end else if (state_q == BST_UPD_IR) begin
      test_drive_q <= (ir_sh_q == `BST_IR_EXTEST);
      test_off_q <= (ir_sh_q == `BST_IR_HIGHZ);
    end
  end

  // system side: register pin levels so the test domain samples a
  // clean flop output; normal operation is not touched by sampling
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_snap_q <= '0;
    end else begin
      pin_snap_q <= pin_level_i;
    end
  end

  // only the update toggle crosses through flops; the update stage is
  // read once the toggle has settled, since it holds until the next
  // update-dr. limitation: two update-dr closer than about five system
  // clocks may be seen as one, and the earlier word is then skipped
  bst_sync #(
    .WIDTH(1),
    .RST_VAL(1'h0)
  ) u_upd_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(upd_tgl_q),
    .sync_o(upd_tgl_clk)
  );

  // take the whole update stage on each new toggle value
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      upd_seen_q <= 1'h0;
      upd_word_q <= '0;
    end else if (upd_tgl_clk != upd_seen_q) begin
      upd_seen_q <= upd_tgl_clk;
      upd_word_q <= bsr_upd;
    end
  end

  // the two test modes cross as independent levels; they never both
  // stand high, so a one-cycle skew between them is harmless
  bst_sync #(
    .WIDTH(2),
    .RST_VAL(2'h0)
  ) u_mode_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i({test_off_q, test_drive_q}),
    .sync_o(mode_clk)
  );

  // pin drive: core values in normal operation and highz, update stage in extest
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_out_q <= '0;
    end else if (mode_clk[0]) begin
      pin_out_q <= upd_word_q;
    end else begin
      pin_out_q <= core_out_i;
    end
  end

  // driver disable for the high-impedance test mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drv_off_q <= 1'h0;
    end else begin
      drv_off_q <= mode_clk[1];
    end
  end

  assign pin_out_o = pin_out_q;
  assign pin_drv_off_o = drv_off_q;
  assign tap_state_o = state_q;
  assign ir_o = ir_q;

endmodule // bst_tap

// ---- test/bst_tap_props.sv ----
`include "bst_params.svh"

// watches the test port and the pin mode of the tap from its ports only
module bst_tap_props
  import bst_pkg::*;
#(
  parameter int BSR_LEN = `BST_BSR_LEN
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  // test port
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  // status
  input wire logic pin_drv_off_o,
  input bst_pkg::bst_state_t tap_state_o,
  input wire logic [`BST_IR_WIDTH-1:0] ir_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // shift-ir entered straight from capture-ir
  sequence enter_shir;
    tap_state_o == BST_CAP_IR ##1 tap_state_o == BST_SH_IR;
  endsequence

  // a data shift while an instruction other than extest, sample or highz is active
  sequence shift_byp;
    tap_state_o == BST_SH_DR
      && !(ir_o inside {`BST_IR_EXTEST, `BST_IR_SAMPLE, `BST_IR_HIGHZ});
  endsequence

  tlr_hold_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    tap_state_o == BST_TLR && tms_i |=> tap_state_o == BST_TLR) else $error("reset state left");
  tlr_exit_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    tap_state_o == BST_TLR && !tms_i |=> tap_state_o == BST_RTI) else $error("idle not reached");
  five_ones_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    tms_i [*5] |=> tap_state_o == BST_TLR) else $error("five highs did not reset");
  oe_shift_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    !tdo_oe_n_o == (tap_state_o inside {BST_SH_IR, BST_SH_DR})) else $error("tdo enable wrong");
  byp_path_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    shift_byp ##1 shift_byp |-> tdo_o == $past(tdi_i)) else $error("bypass not one cell");
  cap_ir_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    enter_shir |-> tdo_o ##1 tap_state_o != BST_SH_IR || !tdo_o) else $error("ir capture bits");
  ir_hold_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    tap_state_o inside {BST_RTI, BST_SH_IR, BST_SH_DR} |=> $stable(ir_o)) else $error("ir moved");
  ir_reset_a: assert property (
    @(posedge tck_i) disable iff (srst_i)
    (tap_state_o == BST_TLR) [*2] |=> ir_o == `BST_RST_IR) else $error("reset ir wrong");
  drv_off_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $changed(pin_drv_off_o) |-> pin_drv_off_o == (ir_o == `BST_IR_HIGHZ)) else $error("drv off");
endmodule // bst_tap_props

bind bst_tap bst_tap_props #(.BSR_LEN(BSR_LEN)) i_bst_tap_props (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .tck_i(tck_i),
  .tms_i(tms_i),
  .tdi_i(tdi_i),
  .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o),
  .pin_drv_off_o(pin_drv_off_o),
  .tap_state_o(tap_state_o),
  .ir_o(ir_o)
);

// ---- test/bst_ctl_model.sv ----
// external test controller: tck stands low between frames
module bst_ctl_model (
  // test port towards the device
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_bit; // last value seen, inverted when tdo is released

  // idle levels stand in for the pull-ups on mode select and data in
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    last_bit = 1'b0;
  end

  // one 12 ns tck period; tdo is taken just before the rising edge
  task automatic step(input logic t, input logic d, output logic o);
    tms_o = t;
    tdi_o = d;
    #6;
    o = tdo_oe_n_i ? ~last_bit : tdo_i;
    last_bit = o;
    tck_o = 1'b1;
    #6;
    tck_o = 1'b0;
  endtask

  // n periods at a fixed mode select; five highs reach reset
  task automatic idle(input logic t, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(t, 1'b1, o);
    end
  endtask

  // one full ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [107:0] din,
                      output logic [107:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) begin
      step(1'b1, 1'b1, o);
    end
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule // bst_ctl_model

// ---- test/bst_tap_tb_top.sv ----
`include "bst_params.svh"

// drives the tap through the controller model and checks pins and chains
module bst_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bst_pkg::*;
  localparam logic [107:0] PAT = 108'h123456789abcdef0fedcba98765;
  logic clk_i, srst_i, tck, tms, tdi, tdo, tdo_oe_n, drv_off;
  logic [107:0] core_out, pin_level, pin_out, d;
  bst_state_t state;
  logic [2:0] ir;
  int errors, n_compared, cycles;

  bst_tap #(.BSR_LEN(108)) i_bst_tap (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .core_out_i(core_out),
    .pin_level_i(pin_level), .pin_out_o(pin_out), .pin_drv_off_o(drv_off),
    .tap_state_o(state), .ir_o(ir));
  bst_ctl_model i_bst_ctl_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_n_i(tdo_oe_n));

  // 50 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test;
    end
  end

  task automatic chk(input string what, input logic [107:0] exp, input logic [107:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // lets pin syncs and mode changes land in both domains
  task automatic settle;
    i_bst_ctl_model.idle(1'b0, 6);
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic t_reset;
    fork
      repeat (6) @(posedge clk_i);
      i_bst_ctl_model.idle(1'b1, 8);
    join
    srst_i <= 1'b0;
    i_bst_ctl_model.idle(1'b1, 6);
    #1;
    chk("reset state", BST_TLR, state);
    chk("reset ir", `BST_RST_IR, ir);
    chk("reset tdo enable", 1, tdo_oe_n);
    chk("reset drivers", 0, drv_off);
    i_bst_ctl_model.idle(1'b0, 1);
  endtask

  task automatic t_sample;
    i_bst_ctl_model.scan(1'b1, 3, `BST_IR_SAMPLE, d);
    chk("ir capture", `BST_IR_CAPTURE, d);
    @(posedge clk_i);
    core_out <= ~PAT;
    pin_level <= PAT;
    settle;
    chk("pins in use", ~PAT, pin_out);
    i_bst_ctl_model.scan(1'b0, 108, '0, d);
    chk("sampled chain", PAT, d);
  endtask

  task automatic t_extest;
    i_bst_ctl_model.scan(1'b1, 3, `BST_IR_EXTEST, d);
    i_bst_ctl_model.scan(1'b0, 108, PAT << 4, d);
    chk("captured pins", PAT, d);
    settle;
    chk("driven pins", PAT << 4, pin_out);
  endtask

  task automatic t_highz_bypass;
    i_bst_ctl_model.scan(1'b1, 3, `BST_IR_HIGHZ, d);
    settle;
    chk("drivers off", 1, drv_off);
    i_bst_ctl_model.scan(1'b1, 3, 108'h2, d);
    settle;
    chk("drivers on", 0, drv_off);
    chk("pins normal", ~PAT, pin_out);
    i_bst_ctl_model.scan(1'b0, 4, 108'hb, d);
    chk("bypass path", 108'h6, d);
  endtask

  // five highs from the middle of a data shift
  task automatic t_five_ones;
    i_bst_ctl_model.idle(1'b1, 1);
    i_bst_ctl_model.idle(1'b0, 2);
    i_bst_ctl_model.idle(1'b1, 5);
    #1;
    chk("five highs state", BST_TLR, state);
    chk("five highs tdo enable", 1, tdo_oe_n);
    i_bst_ctl_model.idle(1'b1, 1);
    chk("five highs ir", `BST_RST_IR, ir);
    i_bst_ctl_model.idle(1'b0, 1);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    srst_i = 1'b1;
    core_out = '0;
    pin_level = '0;
    t_reset;
    t_sample;
    t_extest;
    t_highz_bypass;
    t_five_ones;
    end_of_test;
  end
endmodule // bst_tap_tb_top
